/* core_status_regs.sv */
/*
 * Core status register and write-only timer configuration register.
 * Assumes a single core clock; reset cause is held stable during reset
 * and sampled by the first clock after release.
 */
`timescale 1ns/1ps
`default_nettype none
`include "core_status_params.svh"
module core_status_regs (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire core_status_pkg::reset_cause_type I_RESET_CAUSE,
	input wire core_status_pkg::alu_req_type I_REQ,
	input wire logic I_CFG_LOAD,
	input wire logic I_WDT_KICK,
	input wire logic I_SLEEP,
	input wire logic I_WDT_TIMEOUT,
	output logic [7:0] O_STATUS,
	output logic [7:0] O_RESULT,
	output logic [7:0] O_TIMER_CFG,
	output logic O_PAGE_SELECT
);
	import core_status_pkg::*;

	alu_res_type res;
	logic [7:0] status_q, status_d;
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] result_q, result_d;
	logic cause_pend_q, cause_pend_d;
	logic st_write;

	// ------------------------------------------------------------
	// flag generation
	// ------------------------------------------------------------
	core_status_alu u_alu (
		.i_req(I_REQ),
		.i_carry(status_q[`BIT_C]),
		.o_res(res)
	);

	assign st_write = I_REQ.valid && I_REQ.to_file &&
		(I_REQ.addr == `STATUS_ADDR);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		status_d = status_q;
		cfg_d = cfg_q;
		result_d = result_q;
		cause_pend_d = 1'b0;
		if (I_REQ.valid) begin
			result_d = res.result;
			if (st_write) begin
				// timeout and powerdown stay hardware-owned
				status_d[`BIT_WAKE] = res.result[`BIT_WAKE];
				status_d[6] = 1'b0;
				status_d[`BIT_PAGE] = res.result[`BIT_PAGE];
				if (!res.upd_z)
					status_d[`BIT_Z] = res.result[`BIT_Z];
				if (!res.upd_nib_c)
					status_d[`BIT_NIB_C] = res.result[`BIT_NIB_C];
				if (!res.upd_c)
					status_d[`BIT_C] = res.result[`BIT_C];
			end
			if (res.upd_z)
				status_d[`BIT_Z] = res.z;
			if (res.upd_nib_c)
				status_d[`BIT_NIB_C] = res.nib_c;
			if (res.upd_c)
				status_d[`BIT_C] = res.c;
		end
		if (cause_pend_q) begin
			// cause is known only once reset has let go; it beats a
			// software write to the wake bit in the same cycle
			status_d[`BIT_WAKE] = (I_RESET_CAUSE == RST_WAKE);
			if (I_RESET_CAUSE == RST_POR) begin
				status_d[`BIT_TIMEOUT] = 1'b1;
				status_d[`BIT_POWERDOWN] = 1'b1;
			end
			if (I_RESET_CAUSE == RST_WDT)
				status_d[`BIT_TIMEOUT] = 1'b0;
		end
		if (I_CFG_LOAD)
			cfg_d = I_REQ.acc;
		if (I_WDT_KICK) begin
			status_d[`BIT_TIMEOUT] = 1'b1;
			status_d[`BIT_POWERDOWN] = 1'b1;
		end
		if (I_SLEEP) begin
			status_d[`BIT_TIMEOUT] = 1'b1;
			status_d[`BIT_POWERDOWN] = 1'b0;
		end
		if (I_WDT_TIMEOUT)
			status_d[`BIT_TIMEOUT] = 1'b0;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			status_q <= `STATUS_RESET;
			cfg_q <= `CFG_RESET;
			result_q <= 8'h00;
			cause_pend_q <= 1'b1;
		end else begin
			status_q <= status_d;
			cfg_q <= cfg_d;
			result_q <= result_d;
			cause_pend_q <= cause_pend_d;
		end
	end

	// config has no read path into the file: only the timer sees it
	always_comb begin
		O_TIMER_CFG = cfg_q;
		O_STATUS = status_q;
		O_RESULT = result_q;
		O_PAGE_SELECT = status_q[`BIT_PAGE];
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_add_nib_carry;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(I_REQ.valid && I_REQ.op == OP_ADD && !cause_pend_q && !I_CFG_LOAD)
		|=> status_q[`BIT_NIB_C] ==
		(({1'b0, $past(I_REQ.file_val[3:0])} +
		{1'b0, $past(I_REQ.acc[3:0])}) > 5'h0F);
	endproperty
	a_add_nib_carry: assert property (p_add_nib_carry)
		else $error("nibble carry wrong after add");

	property p_rot_right;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(I_REQ.valid && I_REQ.op == OP_ROT_RIGHT)
		|=> status_q[`BIT_C] == $past(I_REQ.file_val[0]);
	endproperty
	a_rot_right: assert property (p_rot_right)
		else $error("carry not loaded from lsb on rotate right");

	property p_rot_left;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(I_REQ.valid && I_REQ.op == OP_ROT_LEFT)
		|=> status_q[`BIT_C] == $past(I_REQ.file_val[7]);
	endproperty
	a_rot_left: assert property (p_rot_left)
		else $error("carry not loaded from msb on rotate left");

	property p_cfg_hold;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!I_CFG_LOAD |=> $stable(O_TIMER_CFG);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config changed without load");

	property p_cfg_load;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		I_CFG_LOAD |=> O_TIMER_CFG == $past(I_REQ.acc);
	endproperty
	a_cfg_load: assert property (p_cfg_load)
		else $error("config not loaded from accumulator");

	property p_cfg_reset;
		@(posedge I_CLOCK)
		$fell(I_SYS_RST) |-> O_TIMER_CFG == `CFG_RESET;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset)
		else $error("config not all ones after reset");

	property p_wake;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		cause_pend_q |=>
		status_q[`BIT_WAKE] == ($past(I_RESET_CAUSE) == RST_WAKE);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake bit does not match reset cause");

	property p_page;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		st_write |=> O_PAGE_SELECT == $past(res.result[`BIT_PAGE]);
	endproperty
	a_page: assert property (p_page)
		else $error("page select not written");

	property p_hw_flags_ro;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(st_write && !cause_pend_q && !I_WDT_KICK && !I_SLEEP
		&& !I_WDT_TIMEOUT) |=>
		$stable(status_q[`BIT_TIMEOUT:`BIT_POWERDOWN]);
	endproperty
	a_hw_flags_ro: assert property (p_hw_flags_ro)
		else $error("timeout or powerdown written by software");

	property p_sleep;
		@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(I_SLEEP && !I_WDT_TIMEOUT) |=>
		status_q[`BIT_TIMEOUT] && !status_q[`BIT_POWERDOWN];
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep did not set timeout and clear powerdown");

	c_add: cover property (@(posedge I_CLOCK) I_REQ.valid &&
		I_REQ.op == OP_ADD && st_write);
	c_load: cover property (@(posedge I_CLOCK) I_CFG_LOAD);
	c_wdt: cover property (@(posedge I_CLOCK) I_WDT_TIMEOUT);
	c_rot: cover property (@(posedge I_CLOCK) I_REQ.valid &&
		I_REQ.op == OP_ROT_LEFT);
endmodule
`default_nettype wire

/* core_status_params.svh */
/*
 * Constants for the core status and timer configuration register logic.
 * Assumes inclusion by bare name from the core_status_regs design module.
 */
// Overview of operation
// - rotate through carry loads carry with the bit shifted out
// - eight-bit write-only timer configuration register, never read back
// - configuration-load instruction copies the whole accumulator into it
// - any reset sets all eight configuration bits to one
// - wake bit set on pin-change reset, cleared on every other reset
// - status holds a program page select bit for larger program memories
// - flag-updating writes to status skip flags; timeout/powerdown read-only
`ifndef CORE_STATUS_PARAMS_SVH
`define CORE_STATUS_PARAMS_SVH

`define STATUS_ADDR 5'h03
`define BIT_WAKE 7
`define BIT_PAGE 5
`define BIT_TIMEOUT 4
`define BIT_POWERDOWN 3
`define BIT_Z 2
`define BIT_NIB_C 1
`define BIT_C 0
`define STATUS_RESET 8'h18
`define CFG_RESET 8'hFF

`endif

/* core_status_pkg.sv */
/*
 * Types shared by the status register logic.
 * Assumes the datapath decodes one operation per cycle.
 */
`default_nettype none
package core_status_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_SUB,
		OP_ROT_RIGHT,
		OP_ROT_LEFT,
		OP_LOGIC,
		OP_MOVE
	} alu_op_type;

	typedef struct packed {
		logic valid;
		alu_op_type op;
		logic [7:0] file_val;
		logic [7:0] acc;
		logic to_file;
		logic [4:0] addr;
	} alu_req_type;

	typedef struct packed {
		logic [7:0] result;
		logic z;
		logic nib_c;
		logic c;
		logic upd_z;
		logic upd_c;
		logic upd_nib_c;
	} alu_res_type;

	typedef enum logic [1:0] {
		RST_POR,
		RST_PIN,
		RST_WAKE,
		RST_WDT
	} reset_cause_type;
endpackage
`default_nettype wire

/* core_status_alu.sv */
/*
 * Arithmetic and rotate flag generation.
 * Assumes the request is valid and stable for the current cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module core_status_alu
	import core_status_pkg::*;
(
	input wire core_status_pkg::alu_req_type i_req,
	input wire logic i_carry,
	output core_status_pkg::alu_res_type o_res
);
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		o_res = '0;
		sum = 9'h000;
		nib = 5'h00;
		case (i_req.op)
			OP_ADD: begin
				sum = {1'b0, i_req.file_val} + {1'b0, i_req.acc};
				nib = {1'b0, i_req.file_val[3:0]} + {1'b0, i_req.acc[3:0]};
				o_res.result = sum[7:0];
				o_res.c = sum[8];
				o_res.nib_c = nib[4];
				o_res.upd_c = 1'b1;
				o_res.upd_nib_c = 1'b1;
				o_res.upd_z = 1'b1;
			end
			OP_SUB: begin
				// two's complement add: carry out means no borrow
				sum = {1'b0, i_req.file_val} + {1'b0, ~i_req.acc} + 9'h001;
				nib = {1'b0, i_req.file_val[3:0]} + {1'b0, ~i_req.acc[3:0]}
					+ 5'h01;
				o_res.result = sum[7:0];
				o_res.c = sum[8];
				o_res.nib_c = nib[4];
				o_res.upd_c = 1'b1;
				o_res.upd_nib_c = 1'b1;
				o_res.upd_z = 1'b1;
			end
			OP_ROT_RIGHT: begin
				o_res.result = {i_carry, i_req.file_val[7:1]};
				o_res.c = i_req.file_val[0];
				o_res.upd_c = 1'b1;
			end
			OP_ROT_LEFT: begin
				o_res.result = {i_req.file_val[6:0], i_carry};
				o_res.c = i_req.file_val[7];
				o_res.upd_c = 1'b1;
			end
			OP_LOGIC: begin
				o_res.result = i_req.acc;
				o_res.upd_z = 1'b1;
			end
			OP_MOVE: begin
				o_res.result = i_req.acc;
			end
			default: begin
				o_res.result = i_req.file_val;
			end
		endcase
		o_res.z = (o_res.result == 8'h00);
	end
endmodule
`default_nettype wire

/* core_status_regs_tb.sv */
/*
 * Self-checking bench for the status and timer configuration registers.
 * Assumes the package, parameter header and design files compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module core_status_regs_tb;
	import core_status_pkg::*;
	logic clk, rst, cfg_ld, kick, slp, tmo, page;
	reset_cause_type cause;
	alu_req_type req;
	logic [7:0] st, res, cfg;
	int n_mismatch, n_checks;

	core_status_regs i_dut (
		.I_CLOCK(clk),
		.I_SYS_RST(rst),
		.I_RESET_CAUSE(cause),
		.I_REQ(req),
		.I_CFG_LOAD(cfg_ld),
		.I_WDT_KICK(kick),
		.I_SLEEP(slp),
		.I_WDT_TIMEOUT(tmo),
		.O_STATUS(st),
		.O_RESULT(res),
		.O_TIMER_CFG(cfg),
		.O_PAGE_SELECT(page)
	);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// mask lets one compare skip bits a test cannot predict
	task automatic chk(input logic [7:0] got, exp, m);
		n_checks++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// strobes drop at the edge that takes them; check after it lands
	task automatic step();
		@(posedge clk);
		req <= '0;
		cfg_ld <= 1'h0;
		kick <= 1'h0;
		slp <= 1'h0;
		tmo <= 1'h0;
		#1;
	endtask

	task automatic alu(input alu_op_type op, input logic [7:0] f, a,
		input logic tf, input logic [4:0] ad);
		@(posedge clk);
		req <= '{1'h1, op, f, a, tf, ad};
		step();
	endtask

	task automatic ev(input logic k, s, t, l, input logic [7:0] a);
		@(posedge clk);
		kick <= k;
		slp <= s;
		tmo <= t;
		cfg_ld <= l;
		req <= '{1'h0, OP_NONE, 8'h00, a, 1'h0, 5'h00};
		step();
	endtask

	task automatic do_reset(input reset_cause_type c);
		@(posedge clk);
		rst <= 1'h1;
		cause <= c;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst = 1'h1;
		cause = RST_POR;
		req = '0;
		cfg_ld = 1'h0;
		kick = 1'h0;
		slp = 1'h0;
		tmo = 1'h0;
		n_mismatch = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(st, 8'h18, 8'hFF);
		chk(cfg, 8'hFF, 8'hFF);
		$display("test reset done");
		alu(OP_ADD, 8'h0F, 8'h01, 1'h0, 5'h10);
		chk(res, 8'h10, 8'hFF);
		chk(st, 8'h02, 8'h07);
		alu(OP_ADD, 8'hFF, 8'h01, 1'h0, 5'h10);
		chk(st, 8'h07, 8'h07);
		alu(OP_SUB, 8'h05, 8'h01, 1'h0, 5'h10);
		chk(res, 8'h04, 8'hFF);
		chk(st, 8'h03, 8'h07);
		alu(OP_SUB, 8'h01, 8'h02, 1'h0, 5'h10);
		chk(st, 8'h00, 8'h07);
		alu(OP_ROT_RIGHT, 8'h81, 8'h00, 1'h0, 5'h10);
		chk(res, 8'h40, 8'hFF);
		chk(st, 8'h01, 8'h01);
		alu(OP_ROT_LEFT, 8'h01, 8'h00, 1'h0, 5'h10);
		chk(res, 8'h03, 8'hFF);
		chk(st, 8'h00, 8'h01);
		alu(OP_ROT_LEFT, 8'h80, 8'h00, 1'h0, 5'h10);
		chk(st, 8'h01, 8'h01);
		// logic op: zero follows the result, carries are left alone
		alu(OP_LOGIC, 8'h3C, 8'h00, 1'h0, 5'h10);
		chk(res, 8'h00, 8'hFF);
		chk(st, 8'h05, 8'h07);
		$display("test alu done");
		ev(1'h0, 1'h0, 1'h0, 1'h1, 8'h5A);
		chk(cfg, 8'h5A, 8'hFF);
		alu(OP_MOVE, 8'h00, 8'hA5, 1'h1, 5'h10);
		chk(cfg, 8'h5A, 8'hFF);
		ev(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
		chk(st, 8'h10, 8'h18);
		alu(OP_MOVE, 8'h00, 8'hFF, 1'h1, 5'h03);
		chk(st, 8'h37, 8'h7F);
		chk({7'h00, page}, 8'h01, 8'hFF);
		alu(OP_ADD, 8'h00, 8'h00, 1'h1, 5'h03);
		chk(st, 8'h14, 8'h7F);
		chk({7'h00, page}, 8'h00, 8'hFF);
		ev(1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
		chk(st, 8'h00, 8'h18);
		ev(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
		chk(st, 8'h18, 8'h18);
		ev(1'h1, 1'h0, 1'h1, 1'h0, 8'h00);
		chk(st, 8'h08, 8'h18);
		$display("test events done");
		do_reset(RST_WAKE);
		chk(st, 8'h80, 8'h80);
		chk(cfg, 8'hFF, 8'hFF);
		do_reset(RST_WDT);
		chk(st, 8'h00, 8'h90);
		do_reset(RST_PIN);
		chk(st, 8'h18, 8'h98);
		$display("test reset causes done");
		end_of_test();
	end

	// whole run needs well under 200 cycles
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire
